// ===== verilog/rcfg_top.sv
`timescale 1ns/10ps
// Summary of operation
// (R1) Interrupt pin is level-sensitive when irq_edge_select is 0, edge-sensitive when 1.
// (R2) Edge select, delay and rate bits: one write in first 64 cycles unless special.
// (R3) clock_monitor_enable is always writable; when set, clock failure starts a reset.
// (R4) Watchdog divides the E clock by two to the fifteenth, then scales further.
// (R5) Rate codes 00..11 scale by 1, 4, 16, 64; reset picks the shortest.
// (R6) Watchdog timeout forces reset only while watchdog_disable is 0.
// (R7) After any reset the watchdog follows watchdog_disable and runs at shortest rate.
// (R8) Normal modes fetch vectors at FFFE, FFFC, FFFA, high byte then low byte.
// (R9) Special modes fetch vectors at BFFE, BFFC, BFFA for the same causes.
// (R10) Vector fetch takes the first three cycles, then execution starts.
// (R11) Reset sets the X, I and S bits of the condition codes.
// (R12) Reset loads the mapping register with 01.
// (R13) Reset clears timer count, prescaler, masks, flags; compares load FFFF.
// (R14) Reset selects compare 5 on the shared channel with no pin action.
// (R15) Reset clears the real-time interrupt and disables the pulse accumulator.
// (R16) Reset loads baud 04, masks serial interrupts, disables transmitter and receiver.
// (R17) Reset sets transmit-empty and transmit-complete, clears all receive status.
// (R18) Reset disables the SPI and clears adc_power_up.
// (R19) Reset disables EEPROM programming for normal reads.
// (R20) Reset loads priority select 0110 and makes the interrupt pin level-sensitive.
// (R21) Mode bits capture the mode pins at reset release; special-mode writes change mode.
// (R22) special_mode_bit is inverse of mode_pin_b; mode_a_bit follows mode_pin_a.
// (R23) Reset sets osc_delay_enable and clears clock_monitor_enable.
// (R24) Simultaneous requests are served by fixed priority; software may promote one.
// (R25) Pin reset beats clock monitor reset, which beats watchdog reset.
// (R26) Software services the watchdog with 55 then AA before the timeout.
// (R27) Option bit 2 reads 0 and ignores writes.
module rcfg_top #(
    parameter int WD_DIV_LOG2 = rcfg_pkg::WD_DIV_EXP,
    parameter logic [7:0] CFG_RESET = rcfg_pkg::CFG_RESET_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [15:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic irq_pin_n,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic clk_fail_pin,
    input wire logic cpu_i_mask,
    input wire logic irq_ack,
    input wire logic [rcfg_pkg::NUM_INT-2:0] periph_int_req,
    output logic cpu_reset,
    output logic vec_fetch,
    output logic [15:0] vec_addr,
    output logic cpu_run,
    output rcfg_pkg::rcfg_cause_e reset_cause,
    output rcfg_pkg::rcfg_opt_s option_out,
    output rcfg_pkg::rcfg_mode_s mode_out,
    output rcfg_pkg::rcfg_init_s init_out,
    output logic irq_req,
    output logic int_any,
    output logic [3:0] int_sel
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic irq_s;
    logic mode_a_s;
    logic mode_b_s;
    logic cm_fail_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Idle levels: pins high, clock-fail detector low, so no false failure.
            sync1_q <= 4'hE;
            sync2_q <= 4'hE;
        end else begin
            sync1_q <= {irq_pin_n, mode_pin_a, mode_pin_b, clk_fail_pin};
            sync2_q <= sync1_q;
        end
    end
    assign {irq_s, mode_a_s, mode_b_s, cm_fail_s} = sync2_q;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic wr_q;
    logic rd_q;
    logic [13:0] idx_q;
    logic opt_wr;
    logic wds_wr;
    logic pri_wr;
    logic cfg_wr;

    // Reads take one wait state so a read right after a write sees it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= 14'h0000;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            rd_q <= hsel && htrans[1] && !hwrite;
            idx_q <= haddr[15:2];
        end else begin
            rd_q <= 1'b0;
        end
    end

    assign opt_wr = wr_q && idx_q == rcfg_pkg::OPT_IDX[13:0];
    assign wds_wr = wr_q && idx_q == rcfg_pkg::WDS_IDX[13:0];
    assign pri_wr = wr_q && idx_q == rcfg_pkg::PRI_IDX[13:0];
    assign cfg_wr = wr_q && idx_q == rcfg_pkg::CFG_IDX[13:0];

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    rcfg_pkg::rcfg_state_e st_q;
    rcfg_pkg::rcfg_opt_s opt_q;
    rcfg_pkg::rcfg_mode_s mode_q;
    logic [2:0] hold_q;
    logic wd_off_q;
    logic wd_to;
    logic cm_rst;
    logic wd_rst;
    logic [7:0] cfg_q;
    logic [7:0] vec_hi;
    logic [7:0] vec_lo;

    assign cm_rst = st_q != rcfg_pkg::ST_HOLD && opt_q.clock_monitor_enable && cm_fail_s;
    assign wd_rst = st_q != rcfg_pkg::ST_HOLD && wd_to && !wd_off_q;
    assign vec_hi = mode_b_s ? rcfg_pkg::VEC_NORMAL_HI : rcfg_pkg::VEC_SPECIAL_HI;

    always_comb begin
        unique case (reset_cause)
            rcfg_pkg::CAUSE_CLKMON: vec_lo = rcfg_pkg::VEC_CLKMON_LO;
            rcfg_pkg::CAUSE_WDOG: vec_lo = rcfg_pkg::VEC_WDOG_LO;
            default: vec_lo = rcfg_pkg::VEC_POR_LO;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= rcfg_pkg::ST_HOLD;
            hold_q <= rcfg_pkg::HOLD_CYCLES - 3'h1;
            reset_cause <= rcfg_pkg::CAUSE_POR;
            cpu_reset <= 1'b1;
            vec_fetch <= 1'b0;
            vec_addr <= 16'h0000;
            cpu_run <= 1'b0;
        end else if (cm_rst || wd_rst) begin
            st_q <= rcfg_pkg::ST_HOLD;
            hold_q <= rcfg_pkg::HOLD_CYCLES - 3'h1;
            reset_cause <= cm_rst ? rcfg_pkg::CAUSE_CLKMON : rcfg_pkg::CAUSE_WDOG; // [R25] [R3] [R6]
            cpu_reset <= 1'b1;
            vec_fetch <= 1'b0;
            cpu_run <= 1'b0;
        end else begin
            unique case (st_q)
                rcfg_pkg::ST_HOLD: begin
                    if (hold_q == 3'h0) begin
                        st_q <= rcfg_pkg::ST_VEC_HI;
                        cpu_reset <= 1'b0;
                        vec_fetch <= 1'b1;
                        vec_addr <= {vec_hi, vec_lo}; // [R8] [R9]
                    end else begin
                        hold_q <= hold_q - 3'h1;
                    end
                end
                rcfg_pkg::ST_VEC_HI: begin
                    st_q <= rcfg_pkg::ST_VEC_LO;
                    vec_addr <= {vec_addr[15:8], vec_addr[7:1], 1'b1}; // [R8]
                end
                rcfg_pkg::ST_VEC_LO: begin
                    st_q <= rcfg_pkg::ST_VEC_GO;
                    vec_fetch <= 1'b0;
                end
                rcfg_pkg::ST_VEC_GO: begin
                    st_q <= rcfg_pkg::ST_RUN; // [R10]
                    cpu_run <= 1'b1;
                end
                rcfg_pkg::ST_RUN: begin
                    st_q <= rcfg_pkg::ST_RUN;
                end
                default: begin
                    st_q <= rcfg_pkg::ST_HOLD;
                    hold_q <= rcfg_pkg::HOLD_CYCLES - 3'h1;
                    cpu_reset <= 1'b1;
                end
            endcase
        end
    end

    // The reset-state image is held constant; peripherals load it while cpu_reset stands.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_out <= rcfg_pkg::INIT_VALUES;
        end else begin
            init_out <= rcfg_pkg::INIT_VALUES; // [R11] [R12] [R13] [R14] [R15] [R16] [R17] [R18] [R19]
        end
    end

    // ----------------------------------------------------------------
    // Option register and write-once window
    // ----------------------------------------------------------------
    logic [6:0] cyc_q;
    logic once_q;
    logic win_open;

    assign win_open = !once_q && cyc_q < rcfg_pkg::WIN_CYCLES;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_q <= 7'h00;
            once_q <= 1'b0;
        end else if (st_q == rcfg_pkg::ST_HOLD) begin
            cyc_q <= 7'h00;
            once_q <= 1'b0;
        end else begin
            if (cyc_q < rcfg_pkg::WIN_CYCLES) begin
                cyc_q <= cyc_q + 7'h01;
            end
            if (opt_wr && !mode_q.special_mode_bit && win_open) begin
                once_q <= 1'b1; // [R2]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_q <= rcfg_pkg::OPT_RESET;
        end else if (st_q == rcfg_pkg::ST_HOLD) begin
            opt_q <= rcfg_pkg::OPT_RESET; // [R23] [R7] [R18]
        end else if (opt_wr) begin
            opt_q.adc_power_up <= hwdata[7];
            opt_q.converter_clock_select <= hwdata[6];
            opt_q.clock_monitor_enable <= hwdata[3]; // [R3]
            if (mode_q.special_mode_bit || win_open) begin
                opt_q.irq_edge_select <= hwdata[5]; // [R2]
                opt_q.osc_delay_enable <= hwdata[4];
                opt_q.watchdog_rate <= hwdata[1:0];
            end
        end
    end
    assign option_out = opt_q;

    // ----------------------------------------------------------------
    // Configuration, priority and mode register
    // ----------------------------------------------------------------
    logic [3:0] psel_q;
    logic irv_q;

    // The configuration byte models a non-volatile cell: internal resets keep it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= CFG_RESET;
            wd_off_q <= CFG_RESET[rcfg_pkg::CFG_WDOFF_BIT];
        end else begin
            if (cfg_wr) begin
                cfg_q <= hwdata[7:0];
            end
            if (st_q == rcfg_pkg::ST_HOLD && hold_q == 3'h0) begin
                wd_off_q <= cfg_q[rcfg_pkg::CFG_WDOFF_BIT]; // [R7]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= '0;
            psel_q <= rcfg_pkg::PSEL_RESET;
            irv_q <= 1'b0;
        end else if (st_q == rcfg_pkg::ST_HOLD) begin
            psel_q <= rcfg_pkg::PSEL_RESET; // [R20]
            if (hold_q == 3'h0) begin
                mode_q.special_mode_bit <= !mode_b_s; // [R21] [R22]
                mode_q.mode_a_bit <= mode_a_s;
                mode_q.boot_rom_select <= !mode_b_s && !mode_a_s;
                irv_q <= !mode_b_s && mode_a_s;
            end
        end else if (pri_wr) begin
            irv_q <= hwdata[4];
            if (cpu_i_mask) begin
                psel_q <= hwdata[3:0]; // [R24]
            end
            if (mode_q.special_mode_bit) begin
                mode_q <= hwdata[7:5]; // [R21]
            end
        end
    end
    assign mode_out = mode_q;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    logic [WD_DIV_LOG2-1:0] wd_pre_q;
    logic [5:0] wd_stg_q;
    logic wd_arm_q;
    logic wd_clr;

    assign wd_clr = wds_wr && wd_arm_q && hwdata[7:0] == rcfg_pkg::WDS_CLEAR;
    assign wd_to = &wd_pre_q && wd_stg_q == rcfg_pkg::WD_SCALE_M1[opt_q.watchdog_rate];

    // Counting stops in the hold state, so every restart begins a full period.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_pre_q <= '0;
            wd_stg_q <= 6'h00;
            wd_arm_q <= 1'b0;
        end else if (st_q == rcfg_pkg::ST_HOLD || wd_clr) begin
            wd_pre_q <= '0; // [R26]
            wd_stg_q <= 6'h00;
            wd_arm_q <= 1'b0;
        end else begin
            wd_pre_q <= wd_pre_q + 1'b1; // [R4]
            if (&wd_pre_q) begin
                wd_stg_q <= wd_to ? 6'h00 : wd_stg_q + 6'h01; // [R5]
            end
            if (wds_wr && hwdata[7:0] == rcfg_pkg::WDS_ARM) begin
                wd_arm_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pin and maskable priority
    // ----------------------------------------------------------------
    logic irq_prev_q;
    logic [rcfg_pkg::NUM_INT-1:0] reqs;
    logic [3:0] promo;
    logic [3:0] first;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_prev_q <= 1'b1;
            irq_req <= 1'b0;
        end else begin
            irq_prev_q <= irq_s;
            if (!opt_q.irq_edge_select) begin
                irq_req <= !irq_s; // [R1]
            end else if (irq_prev_q && !irq_s) begin
                irq_req <= 1'b1; // [R1]
            end else if (irq_ack) begin
                irq_req <= 1'b0;
            end
        end
    end

    assign reqs = {periph_int_req, irq_req};

    always_comb begin
        if (psel_q >= 4'h8) begin
            promo = psel_q - 4'h6;
        end else if (psel_q == 4'h7) begin
            promo = 4'h1;
        end else if (psel_q >= 4'h5) begin
            promo = 4'h0;
        end else begin
            promo = psel_q + 4'hA;
        end
        first = 4'h0;
        for (int i = rcfg_pkg::NUM_INT - 1; i >= 0; i--) begin
            if (reqs[i]) begin
                first = 4'(i);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_any <= 1'b0;
            int_sel <= 4'h0;
        end else begin
            int_any <= |reqs;
            int_sel <= reqs[promo] ? promo : first; // [R24]
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
            if (rd_q) begin
                unique case (idx_q)
                    rcfg_pkg::OPT_IDX[13:0]: hrdata <= {24'h0, opt_q[6:2], 1'b0,
                        opt_q.watchdog_rate}; // [R27]
                    rcfg_pkg::PRI_IDX[13:0]: hrdata <= {24'h0, mode_q, irv_q, psel_q};
                    rcfg_pkg::CFG_IDX[13:0]: hrdata <= {24'h0, cfg_q};
                    rcfg_pkg::STA_IDX[13:0]: hrdata <= {27'h0, irq_req, !wd_off_q, win_open,
                        reset_cause};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_irq_level_follow: assert property ( // [R1]
        !opt_q.irq_edge_select && !irq_s |=> irq_req)
        else $error("level irq not followed");
    a_write_once_lock: assert property ( // [R2]
        opt_wr && !mode_q.special_mode_bit && !win_open |=>
        $stable({opt_q.irq_edge_select, opt_q.osc_delay_enable, opt_q.watchdog_rate}))
        else $error("protected option bits changed after window");
    a_clkmon_reset: assert property ( // [R3]
        cm_rst |=> st_q == rcfg_pkg::ST_HOLD && reset_cause == rcfg_pkg::CAUSE_CLKMON
        && cpu_reset)
        else $error("clock monitor reset not taken");
    a_wdog_reset: assert property ( // [R6]
        wd_to && !wd_off_q && st_q == rcfg_pkg::ST_RUN && !cm_rst |=>
        reset_cause == rcfg_pkg::CAUSE_WDOG && cpu_reset)
        else $error("watchdog reset not taken");
    a_wdog_masked: assert property ( // [R6]
        wd_to && wd_off_q && st_q == rcfg_pkg::ST_RUN && !cm_rst |=> cpu_run)
        else $error("disabled watchdog forced reset");
    a_vector_seq: assert property ( // [R10]
        st_q == rcfg_pkg::ST_HOLD && hold_q == 3'h0 && !cm_rst |=>
        vec_fetch ##1 vec_fetch && vec_addr[0] ##1 !vec_fetch && !cpu_run ##1 cpu_run)
        else $error("vector fetch sequence wrong");
    a_vector_addr: assert property ( // [R8] [R9]
        st_q == rcfg_pkg::ST_VEC_HI |-> vec_addr[15:8] == (mode_q.special_mode_bit ?
        rcfg_pkg::VEC_SPECIAL_HI : rcfg_pkg::VEC_NORMAL_HI) && vec_addr[7:0] == (
        reset_cause == rcfg_pkg::CAUSE_WDOG ? rcfg_pkg::VEC_WDOG_LO :
        reset_cause == rcfg_pkg::CAUSE_CLKMON ? rcfg_pkg::VEC_CLKMON_LO :
        rcfg_pkg::VEC_POR_LO))
        else $error("wrong restart vector");
    a_reset_options: assert property ( // [R7] [R23] [R20]
        st_q == rcfg_pkg::ST_HOLD |=> opt_q == rcfg_pkg::OPT_RESET
        && psel_q == rcfg_pkg::PSEL_RESET)
        else $error("option reset state wrong");
    a_promote_wins: assert property ( // [R24]
        reqs[promo] |=> int_sel == $past(promo))
        else $error("promoted interrupt lost");
    a_mode_capture: assert property ( // [R22]
        st_q == rcfg_pkg::ST_HOLD && hold_q == 3'h0 |=>
        mode_q.special_mode_bit == !$past(mode_b_s) && mode_q.mode_a_bit == $past(mode_a_s))
        else $error("mode bits not captured");

    c_wdog_reset: cover property (wd_rst);
    c_clkmon_reset: cover property (cm_rst);
    c_service: cover property (wd_clr);
    c_edge_irq: cover property (opt_q.irq_edge_select && irq_req);

endmodule

// ===== verilog/rcfg_pkg.sv
package rcfg_pkg;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [15:0] OPT_IDX = 16'h1039;
    localparam logic [15:0] WDS_IDX = 16'h103A;
    localparam logic [15:0] PRI_IDX = 16'h103C;
    localparam logic [15:0] CFG_IDX = 16'h1040;
    localparam logic [15:0] STA_IDX = 16'h1041;

    // ----------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic adc_power_up;
        logic converter_clock_select;
        logic irq_edge_select;
        logic osc_delay_enable;
        logic clock_monitor_enable;
        logic [1:0] watchdog_rate;
    } rcfg_opt_s;

    localparam rcfg_opt_s OPT_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0};
    localparam int OPT_UNUSED_BIT = 2;
    localparam logic [7:0] CFG_RESET_DEF = 8'h03;
    localparam int CFG_WDOFF_BIT = 2;
    localparam logic [3:0] PSEL_RESET = 4'h6;
    localparam logic [7:0] WDS_ARM = 8'h55;
    localparam logic [7:0] WDS_CLEAR = 8'hAA;

    typedef struct packed {
        logic ccr_x;
        logic ccr_i;
        logic ccr_s;
        logic [7:0] init_map;
        logic [15:0] timer_count;
        logic [15:0] compare_value;
        logic [7:0] baud;
        logic [7:0] serial_status;
        logic [3:0] priority_select;
        logic irq_edge_select;
        logic periph_enables;
    } rcfg_init_s;

    localparam rcfg_init_s INIT_VALUES = '{1'b1, 1'b1, 1'b1, 8'h01, 16'h0000, 16'hFFFF,
        8'h04, 8'hC0, 4'h6, 1'b0, 1'b0};

    typedef struct packed {
        logic boot_rom_select;
        logic special_mode_bit;
        logic mode_a_bit;
    } rcfg_mode_s;

    // ----------------------------------------------------------------
    // Timing, vectors and states
    // ----------------------------------------------------------------
    localparam int WD_DIV_EXP = 15;
    localparam logic [6:0] WIN_CYCLES = 7'h40;
    localparam logic [2:0] HOLD_CYCLES = 3'h4;
    localparam logic [5:0] WD_SCALE_M1 [0:3] = '{6'h00, 6'h03, 6'h0F, 6'h3F};
    localparam logic [7:0] VEC_NORMAL_HI = 8'hFF;
    localparam logic [7:0] VEC_SPECIAL_HI = 8'hBF;
    localparam logic [7:0] VEC_POR_LO = 8'hFE;
    localparam logic [7:0] VEC_CLKMON_LO = 8'hFC;
    localparam logic [7:0] VEC_WDOG_LO = 8'hFA;
    localparam int NUM_INT = 15;

    typedef enum logic [1:0] {
        CAUSE_POR = 2'h0,
        CAUSE_CLKMON = 2'h1,
        CAUSE_WDOG = 2'h2
    } rcfg_cause_e;

    typedef enum logic [4:0] {
        ST_HOLD = 5'b00001,
        ST_VEC_HI = 5'b00010,
        ST_VEC_LO = 5'b00100,
        ST_VEC_GO = 5'b01000,
        ST_RUN = 5'b10000
    } rcfg_state_e;

endpackage

// ===== sim/rcfg_cpu_model.sv
`timescale 1ns/10ps
module rcfg_cpu_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cpu_reset,
    input wire logic irq_req,
    input wire logic [13:0] pend,
    output logic cpu_i_mask,
    output logic irq_ack,
    output logic [13:0] periph_int_req
);
    // Startup code never clears I, so the priority register stays writable.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_i_mask <= 1'b1;
            irq_ack <= 1'b0;
            periph_int_req <= 14'h0000;
        end else begin
            cpu_i_mask <= 1'b1;
            irq_ack <= irq_req & ~irq_ack;
            periph_int_req <= cpu_reset ? 14'h0000 : pend;
        end
    end
endmodule

// ===== sim/rcfg_top_tb_top.sv
`timescale 1ns/10ps
module rcfg_top_tb_top;
    logic hclk, hreadyout, cpu_i_mask, irq_ack, cpu_reset, vec_fetch, cpu_run, irq_req, int_any;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_fail_pin = 1'b0;
    logic irq_pin_n = 1'b1, mode_pin_a = 1'b0, mode_pin_b = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [15:0] haddr = 16'h0000, vec_addr;
    logic [31:0] hwdata = 32'h00000000, hrdata;
    logic [13:0] pend = 14'h2000, periph_int_req;
    logic [3:0] int_sel, ps;
    logic [7:0] r, d, e;
    rcfg_pkg::rcfg_cause_e reset_cause;
    rcfg_pkg::rcfg_mode_s mode_out;
    rcfg_pkg::rcfg_init_s init_out;
    rcfg_pkg::rcfg_opt_s option_out;
    int fail_count = 0, n_checks = 0, seed = 38621, n_hi = 0;

    rcfg_top #(.WD_DIV_LOG2(4), .CFG_RESET(8'h07)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(), .irq_pin_n(irq_pin_n), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
        .clk_fail_pin(clk_fail_pin), .cpu_i_mask(cpu_i_mask), .irq_ack(irq_ack),
        .periph_int_req(periph_int_req), .cpu_reset(cpu_reset), .vec_fetch(vec_fetch),
        .vec_addr(vec_addr), .cpu_run(cpu_run), .reset_cause(reset_cause),
        .option_out(option_out), .mode_out(mode_out), .init_out(init_out),
        .irq_req(irq_req), .int_any(int_any),
        .int_sel(int_sel));
    rcfg_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .cpu_reset(cpu_reset),
        .irq_req(irq_req), .pend(pend), .cpu_i_mask(cpu_i_mask), .irq_ack(irq_ack),
        .periph_int_req(periph_int_req));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #800000;
        fail_count++;
        finish_test();
    end

    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask

    // Both waits are bounded so a stuck sequencer ends in a mismatch, not a hang.
    task automatic wait_vec(input logic [15:0] ev, input logic [1:0] ec);
        int n;
        n = 0;
        while (vec_fetch !== 1'b1 && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        check(vec_addr, ev);
        check(cpu_reset, 1'b0);
        check(reset_cause, ec);
        while (cpu_run !== 1'b1 && n < 5000) begin
            @(posedge hclk);
            n++;
        end
    endtask

    function automatic logic [3:0] exp_sel(input logic [3:0] p, input logic [14:0] q);
        logic [3:0] pr;
        pr = p < 4'h5 ? p + 4'hA : p < 4'h7 ? 4'h0 : p - 4'h6;
        if (q[pr])
            return pr;
        for (int k = 0; k < 15; k++)
            if (q[k])
                return k[3:0];
        return 4'h0;
    endfunction

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wait_vec(16'hFFFE, rcfg_pkg::CAUSE_POR);
        check(init_out, rcfg_pkg::INIT_VALUES);
        check(mode_out, 3'h0);
        bus(1'b0, 16'h40E4, 8'h00);
        check(r, 8'h10);
        check(option_out, rcfg_pkg::OPT_RESET);
        d = 8'($random(seed));
        d[5] = 1'b0;
        bus(1'b1, 16'h40E4, d);
        bus(1'b0, 16'h40E4, 8'h00);
        check(r, d & 8'hFB);
        e = 8'($random(seed));
        bus(1'b1, 16'h40E4, e);
        bus(1'b0, 16'h40E4, 8'h00);
        check(r, (e & 8'hC8) | (d & 8'h33));
        bus(1'b0, 16'h40F0, 8'h00);
        check(r[3:0], 4'h6);
        for (int i = 0; i < 8; i++) begin
            ps = 4'($random(seed));
            pend <= 14'($random(seed)) | 14'h2000;
            bus(1'b1, 16'h40F0, {4'h0, ps});
            repeat (3) @(posedge hclk);
            check(int_sel, exp_sel(ps, {pend, 1'b0}));
            check(int_any, 1'b1);
        end
        irq_pin_n <= 1'b0;
        repeat (4) @(posedge hclk);
        check(irq_req, 1'b1);
        irq_pin_n <= 1'b1;
        repeat (4) @(posedge hclk);
        check(irq_req, 1'b0);
        bus(1'b1, 16'h4100, 8'h03);
        bus(1'b1, 16'h40E4, 8'h08);
        clk_fail_pin <= 1'b1;
        wait_vec(16'hFFFC, rcfg_pkg::CAUSE_CLKMON);
        clk_fail_pin <= 1'b0;
        // Each service pair fits well inside the shortest timeout; four pairs outlast it.
        repeat (4) begin
            bus(1'b1, 16'h40E8, rcfg_pkg::WDS_ARM);
            bus(1'b1, 16'h40E8, rcfg_pkg::WDS_CLEAR);
        end
        check(cpu_run, 1'b1);
        check(reset_cause, rcfg_pkg::CAUSE_CLKMON);
        wait_vec(16'hFFFA, rcfg_pkg::CAUSE_WDOG);
        bus(1'b1, 16'h4100, 8'h07);
        wait_vec(16'hFFFA, rcfg_pkg::CAUSE_WDOG);
        bus(1'b0, 16'h40E4, 8'h00);
        check(r, 8'h10);
        repeat (300) @(posedge hclk);
        check(cpu_run, 1'b1);
        hresetn <= 1'b0;
        mode_pin_b <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wait_vec(16'hBFFE, rcfg_pkg::CAUSE_POR);
        check(mode_out, 3'h6);
        bus(1'b1, 16'h40E4, 8'h21);
        // Edge mode: a pin held low gives one request that the ack then clears.
        irq_pin_n <= 1'b0;
        repeat (8) begin
            @(posedge hclk);
            n_hi += irq_req;
        end
        check(n_hi != 0, 1'b1);
        check(irq_req, 1'b0);
        irq_pin_n <= 1'b1;
        bus(1'b1, 16'h40E4, 8'h02);
        bus(1'b0, 16'h40E4, 8'h00);
        check(r, 8'h02);
        finish_test();
    end
endmodule
